//--- capture_compare_mode_control.sv
// top of the three-module capture/compare array with its register file
`timescale 1ns/100ps
`include "capture_compare_regs.svh"

module capture_compare_mode_control
  import capture_compare_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // special-function bus
  input  wire sfr_req_t   sfr,
  output logic [7:0]      sfr_rdata,
  // flag clears from the array control register
  input  wire logic [2:0] flag_clear,
  // module pins
  input  wire logic [2:0] module_pin_in,
  output logic [2:0]      module_pin_out,
  output logic [2:0]      module_pin_oe,
  // status
  output logic [2:0]      compare_flag,
  output logic [2:0]      compare_irq
);

  localparam logic [7:0] MODE_ADDR [3] = '{`ADDR_MODULE_MODE_0, `ADDR_MODULE_MODE_1,
                                           `ADDR_MODULE_MODE_2};
  localparam logic [7:0] LOW_ADDR  [3] = '{`ADDR_COMPARE_LOW_0, `ADDR_COMPARE_LOW_1,
                                           `ADDR_COMPARE_LOW_2};
  localparam logic [7:0] HIGH_ADDR [3] = '{`ADDR_COMPARE_HIGH_0, `ADDR_COMPARE_HIGH_1,
                                           `ADDR_COMPARE_HIGH_2};

  module_mode_t   mode_reg [3];
  logic [1:0]     cycle_len_reg;
  logic [15:0]    count_reg;
  logic [2:0]     pin_meta_reg;
  logic [2:0]     pin_sync_reg;
  logic [15:0]    compare_value [3];
  compare_write_t cmp_wr [3];

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_meta_reg <= 3'h0;
      pin_sync_reg <= 3'h0;
    end else begin
      pin_meta_reg <= module_pin_in;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shared counter, free running
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count_reg <= `RESET_SHARED_COUNTER;
    end else if (sfr.wr && sfr.addr == `ADDR_SHARED_COUNTER_LOW) begin
      count_reg[7:0] <= sfr.wdata;
    end else begin
      count_reg <= count_reg + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cycle_len_reg <= `RESET_CYCLE_LENGTH;
    end else if (sfr.wr && sfr.addr == `ADDR_MODULATION_CONFIG) begin
      cycle_len_reg <= sfr.wdata[`LSB_CYCLE_LENGTH_SELECT +: 2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-module mode registers and channels
  for (genvar i = 0; i < 3; i++) begin : g_module
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        mode_reg[i] <= `RESET_MODULE_MODE;
      end else if (sfr.wr && sfr.addr == MODE_ADDR[i]) begin
        mode_reg[i] <= sfr.wdata;
      end else if (sfr.wr && sfr.addr == LOW_ADDR[i]) begin
        mode_reg[i].comparator_enable <= 1'b0;
      end else if (sfr.wr && sfr.addr == HIGH_ADDR[i]) begin
        mode_reg[i].comparator_enable <= 1'b1;
      end
    end

    assign cmp_wr[i] = '{wr_low:  sfr.wr && sfr.addr == LOW_ADDR[i],
                         wr_high: sfr.wr && sfr.addr == HIGH_ADDR[i],
                         data:    sfr.wdata};

    capture_compare_channel u_channel (
      .clk           (clk),
      .rstn          (rstn),
      .mode          (mode_reg[i]),
      .cycle_len     (cycle_len_reg),
      .count         (count_reg),
      .cmp_wr        (cmp_wr[i]),
      .flag_clear    (flag_clear[i]),
      .pin_sync      (pin_sync_reg[i]),
      .pin_out       (module_pin_out[i]),
      .pin_oe        (module_pin_oe[i]),
      .flag          (compare_flag[i]),
      .irq           (compare_irq[i]),
      .compare_value (compare_value[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data, registered one cycle after the read strobe
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sfr_rdata <= `READ_UNMAPPED;
    end else if (sfr.rd) begin
      unique case (sfr.addr)
        `ADDR_MODULE_MODE_0:      sfr_rdata <= mode_reg[0];
        `ADDR_MODULE_MODE_1:      sfr_rdata <= mode_reg[1];
        `ADDR_MODULE_MODE_2:      sfr_rdata <= mode_reg[2];
        `ADDR_SHARED_COUNTER_LOW: sfr_rdata <= count_reg[7:0];
        `ADDR_MODULATION_CONFIG:  sfr_rdata <= {6'h00, cycle_len_reg};
        `ADDR_COMPARE_LOW_0:      sfr_rdata <= compare_value[0][7:0];
        `ADDR_COMPARE_LOW_1:      sfr_rdata <= compare_value[1][7:0];
        `ADDR_COMPARE_LOW_2:      sfr_rdata <= compare_value[2][7:0];
        `ADDR_COMPARE_HIGH_0:     sfr_rdata <= compare_value[0][15:8];
        `ADDR_COMPARE_HIGH_1:     sfr_rdata <= compare_value[1][15:8];
        `ADDR_COMPARE_HIGH_2:     sfr_rdata <= compare_value[2][15:8];
        default:                  sfr_rdata <= `READ_UNMAPPED;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_count_low_write;
    sfr.wr && sfr.addr == 8'hf9 |=> count_reg[7:0] == $past(sfr.wdata);
  endproperty
  a_count_low_write: assert property (p_count_low_write) else $error("low byte write lost");

  property p_count_read;
    sfr.rd && sfr.addr == 8'hf9 |=> sfr_rdata == $past(count_reg[7:0]);
  endproperty
  a_count_read: assert property (p_count_read) else $error("low byte read wrong");

  property p_low_clears;
    sfr.wr && sfr.addr == 8'hfb |=> !mode_reg[0].comparator_enable;
  endproperty
  a_low_clears: assert property (p_low_clears) else $error("low write kept enable");

  property p_high_sets;
    sfr.wr && sfr.addr == 8'hea |=> mode_reg[1].comparator_enable;
  endproperty
  a_high_sets: assert property (p_high_sets) else $error("high write left enable clear");

  property p_independent;
    sfr.wr && sfr.addr == 8'hda |=> mode_reg[1] == $past(mode_reg[1]);
  endproperty
  a_independent: assert property (p_independent) else $error("mode write hit other module");

  // per-module checks on what each channel drives at the pins and flags
  for (genvar j = 0; j < 3; j++) begin : g_check
    property p_match_flag;
      mode_reg[j].comparator_enable && mode_reg[j].match_flag_enable
        && count_reg == compare_value[j] |=> compare_flag[j];
    endproperty
    a_match_flag: assert property (p_match_flag) else $error("match did not set flag");

    property p_toggle;
      mode_reg[j].comparator_enable && mode_reg[j].toggle_enable
        && !mode_reg[j].modulation_enable && count_reg == compare_value[j]
        |=> module_pin_out[j] != $past(module_pin_out[j]);
    endproperty
    a_toggle: assert property (p_toggle) else $error("match did not toggle pin");

    property p_freq_toggle;
      mode_reg[j].comparator_enable && mode_reg[j].toggle_enable
        && mode_reg[j].modulation_enable && count_reg[7:0] == compare_value[j][7:0]
        |=> module_pin_out[j] != $past(module_pin_out[j]);
    endproperty
    a_freq_toggle: assert property (p_freq_toggle)
      else $error("frequency match did not toggle pin");

    property p_needs_enable;
      !mode_reg[j].comparator_enable
        |=> !module_pin_oe[j] && module_pin_out[j] == $past(module_pin_out[j]);
    endproperty
    a_needs_enable: assert property (p_needs_enable)
      else $error("pin driven without comparator enable");

    property p_rise_capture;
      $rose(pin_sync_reg[j]) && mode_reg[j].rising_capture_enable
        && !cmp_wr[j].wr_low && !cmp_wr[j].wr_high
        |=> compare_value[j] == $past(count_reg) && compare_flag[j];
    endproperty
    a_rise_capture: assert property (p_rise_capture)
      else $error("rising capture missed");

    property p_fall_capture;
      $fell(pin_sync_reg[j]) && mode_reg[j].falling_capture_enable
        && !cmp_wr[j].wr_low && !cmp_wr[j].wr_high
        |=> compare_value[j] == $past(count_reg) && compare_flag[j];
    endproperty
    a_fall_capture: assert property (p_fall_capture)
      else $error("falling capture missed");

    property p_irq_mask;
      compare_flag[j] && mode_reg[j].compare_irq_enable |=> compare_irq[j];
    endproperty
    a_irq_mask: assert property (p_irq_mask)
      else $error("enabled flag raised no request");

    property p_irq_off;
      !mode_reg[j].compare_irq_enable |=> !compare_irq[j];
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("masked flag raised a request");

    property p_pwm_wide;
      mode_reg[j].comparator_enable && mode_reg[j].modulation_enable
        && !mode_reg[j].toggle_enable && mode_reg[j].wide_modulation_select
        |=> module_pin_out[j] == ($past(count_reg) >= $past(compare_value[j]));
    endproperty
    a_pwm_wide: assert property (p_pwm_wide)
      else $error("wide modulation level wrong");

    property p_narrow8;
      mode_reg[j].comparator_enable && mode_reg[j].modulation_enable
        && !mode_reg[j].toggle_enable && !mode_reg[j].wide_modulation_select
        && cycle_len_reg == `CYCLE_LEN_8
        |=> module_pin_out[j] == ($past(count_reg[7:0]) >= $past(compare_value[j][7:0]));
    endproperty
    a_narrow8: assert property (p_narrow8) else $error("eight bit modulation wrong");

    property p_narrow11;
      mode_reg[j].comparator_enable && mode_reg[j].modulation_enable
        && !mode_reg[j].toggle_enable && !mode_reg[j].wide_modulation_select
        && cycle_len_reg == `CYCLE_LEN_11
        |=> module_pin_out[j] == ($past(count_reg[10:0]) >= $past(compare_value[j][10:0]));
    endproperty
    a_narrow11: assert property (p_narrow11) else $error("eleven bit modulation wrong");
  end

  c_count_write: cover property (sfr.wr && sfr.addr == 8'hf9);
  c_irq:         cover property (compare_irq != 3'h0);

endmodule : capture_compare_mode_control

//--- capture_compare_regs.svh
// register offsets, field positions and reset values of the capture/compare array
`ifndef CAPTURE_COMPARE_REGS_SVH
`define CAPTURE_COMPARE_REGS_SVH

`define ADDR_MODULE_MODE_0       8'hda
`define ADDR_MODULE_MODE_1       8'hdb
`define ADDR_MODULE_MODE_2       8'hdc
`define ADDR_SHARED_COUNTER_LOW  8'hf9
`define ADDR_MODULATION_CONFIG   8'ha1
`define ADDR_COMPARE_LOW_0       8'hfb
`define ADDR_COMPARE_LOW_1       8'he9
`define ADDR_COMPARE_LOW_2       8'heb
`define ADDR_COMPARE_HIGH_0      8'hfc
`define ADDR_COMPARE_HIGH_1      8'hea
`define ADDR_COMPARE_HIGH_2      8'hec

`define BIT_WIDE_MODULATION      7
`define BIT_COMPARATOR_ENABLE    6
`define BIT_RISING_CAPTURE       5
`define BIT_FALLING_CAPTURE      4
`define BIT_MATCH_FLAG           3
`define BIT_TOGGLE               2
`define BIT_MODULATION           1
`define BIT_COMPARE_IRQ          0
`define LSB_CYCLE_LENGTH_SELECT  0

`define RESET_MODULE_MODE        8'h00
`define RESET_SHARED_COUNTER     16'h0000
`define RESET_CYCLE_LENGTH       2'h0
`define RESET_COMPARE            16'h0000
`define READ_UNMAPPED            8'h00

`define CYCLE_LEN_8              2'h0
`define CYCLE_LEN_9              2'h1
`define CYCLE_LEN_10             2'h2
`define CYCLE_LEN_11             2'h3
`define MASK_LEN_8               16'h00ff
`define MASK_LEN_9               16'h01ff
`define MASK_LEN_10              16'h03ff
`define MASK_LEN_11              16'h07ff
`define MASK_LEN_16              16'hffff

`endif

//--- capture_compare_pkg.sv
// types shared by the capture/compare array
package capture_compare_pkg;

  // mode register layout, bit 7 down to bit 0
  typedef struct packed {
    logic wide_modulation_select;
    logic comparator_enable;
    logic rising_capture_enable;
    logic falling_capture_enable;
    logic match_flag_enable;
    logic toggle_enable;
    logic modulation_enable;
    logic compare_irq_enable;
  } module_mode_t;

  // special-function bus request
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_t;

  // compare byte write to one module
  typedef struct packed {
    logic       wr_low;
    logic       wr_high;
    logic [7:0] data;
  } compare_write_t;

  typedef enum logic [4:0] {
    FN_IDLE        = 5'h01,
    FN_COMPARE     = 5'h02,
    FN_PWM_NARROW  = 5'h04,
    FN_PWM_WIDE    = 5'h08,
    FN_FREQ        = 5'h10
  } function_t;

endpackage : capture_compare_pkg

//--- capture_compare_channel.sv
// one capture/compare module: capture, match, toggle, modulation, frequency output
`timescale 1ns/100ps
`include "capture_compare_regs.svh"

module capture_compare_channel
  import capture_compare_pkg::*;
(
  // clock and reset
  input  wire logic           clk,
  input  wire logic           rstn,
  // configuration
  input  wire module_mode_t   mode,
  input  wire logic [1:0]     cycle_len,
  input  wire logic [15:0]    count,
  input  wire compare_write_t cmp_wr,
  input  wire logic           flag_clear,
  // pin side, pin_sync already synchronised
  input  wire logic           pin_sync,
  output logic                pin_out,
  output logic                pin_oe,
  // status
  output logic                flag,
  output logic                irq,
  output logic [15:0]         compare_value
);

  function_t   fn;
  logic        pin_prev_reg;
  logic        rise;
  logic        fall;
  logic        cap_evt;
  logic        match16;
  logic        match_lo;
  logic        flag_set;
  logic [15:0] len_mask;

  ////////////////////////////////////////////////////////////////////////////
  // mode decode, per module only
  always_comb begin
    if (!mode.comparator_enable) begin
      fn = FN_IDLE;
    end else if (mode.toggle_enable && mode.modulation_enable) begin
      fn = FN_FREQ;
    end else if (mode.modulation_enable) begin
      fn = mode.wide_modulation_select ? FN_PWM_WIDE : FN_PWM_NARROW;
    end else begin
      fn = FN_COMPARE;
    end
  end

  always_comb begin
    unique case (cycle_len)
      `CYCLE_LEN_8:  len_mask = `MASK_LEN_8;
      `CYCLE_LEN_9:  len_mask = `MASK_LEN_9;
      `CYCLE_LEN_10: len_mask = `MASK_LEN_10;
      `CYCLE_LEN_11: len_mask = `MASK_LEN_11;
    endcase
    if (mode.wide_modulation_select) begin
      len_mask = `MASK_LEN_16;
    end
  end

  assign rise     = pin_sync & ~pin_prev_reg;
  assign fall     = ~pin_sync & pin_prev_reg;
  assign cap_evt  = (rise & mode.rising_capture_enable)
                  | (fall & mode.falling_capture_enable);
  assign match16  = mode.comparator_enable && (count == compare_value);
  assign match_lo = mode.comparator_enable && (count[7:0] == compare_value[7:0]);
  assign flag_set = cap_evt | (mode.match_flag_enable & match16);

  ////////////////////////////////////////////////////////////////////////////
  // edge history and compare register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_prev_reg <= 1'b0;
    end else begin
      pin_prev_reg <= pin_sync;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      compare_value <= `RESET_COMPARE;
    end else if (cmp_wr.wr_low) begin
      compare_value[7:0] <= cmp_wr.data;
    end else if (cmp_wr.wr_high) begin
      compare_value[15:8] <= cmp_wr.data;
    end else if (cap_evt) begin
      compare_value <= count;
    end else if (fn == FN_FREQ && match_lo) begin
      // next half period starts one step count later
      compare_value[7:0] <= compare_value[7:0] + compare_value[15:8];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flag: a set in the clearing cycle wins
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flag <= 1'b0;
      irq  <= 1'b0;
    end else begin
      flag <= flag_set | (flag & ~flag_clear);
      irq  <= flag & mode.compare_irq_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output pin
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_out <= 1'b0;
      pin_oe  <= 1'b0;
    end else begin
      pin_oe <= (fn != FN_IDLE) && (mode.toggle_enable || mode.modulation_enable);
      unique case (fn)
        FN_IDLE:       pin_out <= pin_out;
        FN_COMPARE:    pin_out <= pin_out ^ (mode.toggle_enable & match16);
        FN_FREQ:       pin_out <= pin_out ^ match_lo;
        FN_PWM_NARROW,
        FN_PWM_WIDE:   pin_out <= (count & len_mask) >= (compare_value & len_mask);
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rstn);

  c_capture: cover property (cap_evt);
  c_freq:    cover property (fn == FN_FREQ && match_lo);
  c_pwm:     cover property (fn == FN_PWM_NARROW && pin_out);

endmodule : capture_compare_channel

//--- capture_compare_pin_model.sv
// partner model of the three module pins: external drivers and wire resolution
`timescale 1ns/100ps

module capture_compare_pin_model (
  // from the design
  input  wire logic [2:0] pin_out,
  input  wire logic [2:0] pin_oe,
  // to the design
  output logic [2:0]      pin_in
);
  logic [2:0] ext_level;

  initial ext_level = 3'h0;

  ////////////////////////////////////////////////////////////////////////////////
  // the device owns the wire while its enable is high
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : ext_level[i];
    end
  end

  task automatic drive(input int idx, input logic level);
    ext_level[idx] = level;
  endtask : drive
endmodule : capture_compare_pin_model

//--- capture_compare_mode_control_tb.sv
// self-checking bench for the capture/compare mode control block
`timescale 1ns/100ps
`include "capture_compare_regs.svh"

module capture_compare_mode_control_tb
  import capture_compare_pkg::*;
;
  logic       clk;
  logic       rstn;
  sfr_req_t   sfr;
  logic [7:0] sfr_rdata;
  logic [2:0] flag_clear;
  logic [2:0] module_pin_in;
  logic [2:0] module_pin_out;
  logic [2:0] module_pin_oe;
  logic [2:0] compare_flag;
  logic [2:0] compare_irq;
  int         failures;
  int         tests_run;
  int         cycles;
  logic [7:0] rd_val;
  logic       pin_was;
  logic [7:0] mode_addr [3] = '{`ADDR_MODULE_MODE_0, `ADDR_MODULE_MODE_1, `ADDR_MODULE_MODE_2};
  logic [7:0] lo_addr [3] = '{`ADDR_COMPARE_LOW_0, `ADDR_COMPARE_LOW_1, `ADDR_COMPARE_LOW_2};
  logic [7:0] hi_addr [3] = '{`ADDR_COMPARE_HIGH_0, `ADDR_COMPARE_HIGH_1, `ADDR_COMPARE_HIGH_2};

  capture_compare_mode_control u_capture_compare_mode_control (
    .clk            (clk),
    .rstn           (rstn),
    .sfr            (sfr),
    .sfr_rdata      (sfr_rdata),
    .flag_clear     (flag_clear),
    .module_pin_in  (module_pin_in),
    .module_pin_out (module_pin_out),
    .module_pin_oe  (module_pin_oe),
    .compare_flag   (compare_flag),
    .compare_irq    (compare_irq)
  );

  capture_compare_pin_model u_capture_compare_pin_model (
    .pin_out (module_pin_out),
    .pin_oe  (module_pin_oe),
    .pin_in  (module_pin_in)
  );

  initial clk = 1'b0;
  always #5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////////
  // comparisons and closing report
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_byte

  task automatic chk_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up

  // hang guard, the whole sequence needs a few hundred cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      wrap_up();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // bus tasks, entered at a falling edge; each but setup assigns the request once, setup once per write
  task automatic sfr_write(input logic [7:0] addr, input logic [7:0] data);
    sfr = {1'b0, 1'b1, addr, data};
    @(negedge clk);
  endtask : sfr_write

  task automatic sfr_read(input logic [7:0] addr);
    sfr = {1'b1, 1'b0, addr, 8'h00};
    @(negedge clk);
    rd_val = sfr_rdata;
  endtask : sfr_read

  task automatic tick(input int n);
    sfr = '0;
    repeat (n) @(negedge clk);
  endtask : tick

  task automatic clr(input logic [2:0] mask);
    sfr = '0;
    flag_clear = mask;
    @(negedge clk);
    flag_clear = 3'h0;
  endtask : clr

  task automatic setup(input int i, input logic [7:0] mode, input logic [15:0] cmp);
    sfr_write(lo_addr[i], cmp[7:0]);
    sfr_write(hi_addr[i], cmp[15:8]);
    sfr_write(mode_addr[i], mode);
  endtask : setup

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rstn = 1'b0;
    sfr = '0;
    flag_clear = 3'h0;
    failures = 0;
    tests_run = 0;
    cycles = 0;
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    sfr_read(`ADDR_SHARED_COUNTER_LOW);
    chk_byte(rd_val, 8'h00);
    for (int i = 0; i < 3; i++) begin
      sfr_read(mode_addr[i]);
      chk_byte(rd_val, `RESET_MODULE_MODE);
    end
    sfr_read(8'h00);
    chk_byte(rd_val, `READ_UNMAPPED);
    // counter low byte write, read back on the next edge
    sfr_write(`ADDR_SHARED_COUNTER_LOW, 8'h55);
    sfr_read(`ADDR_SHARED_COUNTER_LOW);
    chk_byte(rd_val, 8'h55);
    // mode registers hold independent values
    sfr_write(mode_addr[0], 8'ha5);
    sfr_write(mode_addr[1], 8'h5a);
    sfr_write(mode_addr[2], 8'hc3);
    sfr_read(mode_addr[0]);
    chk_byte(rd_val, 8'ha5);
    sfr_read(mode_addr[1]);
    chk_byte(rd_val, 8'h5a);
    sfr_read(mode_addr[2]);
    chk_byte(rd_val, 8'hc3);
    // compare byte writes move the comparator enable
    sfr_write(lo_addr[1], 8'h00);
    sfr_read(mode_addr[1]);
    chk_byte(rd_val, 8'h1a);
    sfr_write(hi_addr[1], 8'h00);
    sfr_read(mode_addr[1]);
    chk_byte(rd_val, 8'h5a);
    // match flag, irq mask and comparator enable
    setup(0, 8'h49, 16'h0010);
    setup(1, 8'h48, 16'h0010);
    setup(2, 8'h08, 16'h0010);
    clr(3'h7);
    sfr_write(`ADDR_SHARED_COUNTER_LOW, 8'h08);
    tick(12);
    chk_byte({5'h00, compare_flag}, 8'h03);
    chk_byte({5'h00, compare_irq}, 8'h01);
    clr(3'h7);
    tick(2);
    chk_byte({5'h00, compare_flag}, 8'h00);
    // rising and falling edge capture
    sfr_write(mode_addr[0], 8'h20);
    sfr_write(mode_addr[1], 8'h10);
    sfr_write(mode_addr[2], 8'h00);
    clr(3'h7);
    for (int i = 0; i < 3; i++) u_capture_compare_pin_model.drive(i, 1'b1);
    tick(6);
    chk_byte({5'h00, compare_flag}, 8'h01);
    clr(3'h7);
    for (int i = 0; i < 3; i++) u_capture_compare_pin_model.drive(i, 1'b0);
    tick(6);
    chk_byte({5'h00, compare_flag}, 8'h02);
    clr(3'h7);
    // pin toggle on match
    setup(2, 8'h44, 16'h0010);
    sfr_write(`ADDR_SHARED_COUNTER_LOW, 8'h08);
    pin_was = module_pin_out[2];
    chk_bit(module_pin_oe[2], 1'b1);
    tick(12);
    chk_bit(module_pin_out[2], ~pin_was);
    chk_bit(compare_flag[2], 1'b0);
    // modulation over every length code and the wide width; for the length codes compare bit 8+c lies
    // just outside the cycle, bit 7+c just inside it
    for (int c = 0; c < 5; c++) begin
      if (c < 4) begin
        sfr_write(`ADDR_MODULATION_CONFIG, 8'(c));
      end
      setup(0, (c < 4) ? 8'h42 : 8'hc2, 16'h0080 | (16'h0100 << c));
      sfr_write(`ADDR_SHARED_COUNTER_LOW, 8'h40);
      tick(3);
      chk_bit(module_pin_out[0], 1'b0);
      sfr_write(`ADDR_SHARED_COUNTER_LOW, 8'h90);
      tick(3);
      chk_bit(module_pin_out[0], c < 4);
      setup(0, (c < 4) ? 8'h42 : 8'hc2, 16'h0080 | (16'h0080 << c));
      sfr_write(`ADDR_SHARED_COUNTER_LOW, 8'h90);
      tick(3);
      chk_bit(module_pin_out[0], c == 0);
    end
    // frequency output: toggle and step the compare low byte
    setup(1, 8'h46, 16'h0810);
    sfr_write(`ADDR_SHARED_COUNTER_LOW, 8'h08);
    pin_was = module_pin_out[1];
    tick(10);
    chk_bit(module_pin_out[1], ~pin_was);
    sfr_read(lo_addr[1]);
    chk_byte(rd_val, 8'h18);
    tick(8);
    chk_bit(module_pin_out[1], pin_was);
    wrap_up();
  end
endmodule : capture_compare_mode_control_tb
